// >>> include/fprs_pkg.sv
/*
 Constants, register map and step table of the fan ramp smoother.
 Assumes a 100 MHz ref_clk and 8-bit duty codes where 255 is 100%.
*/
package fprs_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint CLK_HZ = 100_000_000;
	localparam longint DUTY_FULL = 255;
	localparam longint FAST_SWEEP_MS = 37500; // 0 to 100% at step 1.
	localparam longint SLOW_SWEEP_MS = 52200; // 0 to 100% at step 1.
	// One time slot is the sweep time spread over the full duty range.
	localparam longint FAST_SLOT_CYC =
		(FAST_SWEEP_MS * CLK_HZ) / (64'h3E8 * DUTY_FULL);
	localparam longint SLOW_SLOT_CYC =
		(SLOW_SWEEP_MS * CLK_HZ) / (64'h3E8 * DUTY_FULL);

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] CFG_OFS = 4'h4;
	localparam logic [3:0] STAT_OFS = 4'h8;
	localparam int LOC_RATE_LSB = 0;
	localparam int LOC_EN_BIT = 3;
	localparam int R2_RATE_LSB = 4;
	localparam int R2_EN_BIT = 7;
	localparam int CFG_LOCK_BIT = 0;
	localparam int CFG_SLOW_BIT = 1;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Duty increment per time slot for each rate code.
	function automatic logic [7:0] fprs_step(input logic [2:0] code);
		logic [7:0] s;
		s = 8'h01;
		unique case (code)
			3'h0: s = 8'h01;
			3'h1: s = 8'h02;
			3'h2: s = 8'h03;
			3'h3: s = 8'h04;
			3'h4: s = 8'h08;
			3'h5: s = 8'h0C;
			3'h6: s = 8'h18;
			3'h7: s = 8'h30;
		endcase
		return s;
	endfunction
endpackage

// >>> include/fprs_ifs.sv
/*
 Interfaces between the ramp smoother top, its bus slave and ramps.
 Assumes all parties run on the same ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
// Register access from the bus slave into the register file.
interface fprs_reg_if;
	logic wr_en;
	logic [3:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_ok;
	logic [3:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	modport slave(output wr_en, wr_addr, wr_data, rd_addr,
		input wr_ok, rd_data, rd_ok);
	modport regs(input wr_en, wr_addr, wr_data, rd_addr,
		output wr_ok, rd_data, rd_ok);
endinterface // fprs_reg_if

// Settings and result of one ramp channel.
interface fprs_ramp_if;
	logic [7:0] target;
	logic enable;
	logic [2:0] rate;
	logic tick;
	logic [7:0] duty;
	modport ctrl(output target, enable, rate, tick, input duty);
	modport ramp(input target, enable, rate, tick, output duty);
endinterface // fprs_ramp_if
`default_nettype wire

// >>> core/fprs_ramp.sv
/*
 One ramp channel: moves the fan drive duty toward its target.
 Assumes the tick is a one-cycle pulse once per time slot.
*/
`timescale 1ns/100ps
`default_nettype none
module fprs_ramp
	import fprs_pkg::*;
(
	input wire logic ref_clk, // System clock.
	input wire logic reset, // Asynchronous reset, active high.
	fprs_ramp_if.ramp rp // Channel settings and duty.
);
	typedef struct packed {
		logic [7:0] duty;
	} fprs_ramp_st_t;
	fprs_ramp_st_t q, d;

	// ------------------------------------------------------------
	// Next duty
	// ------------------------------------------------------------
	// Bypass follows the target at once, else step once per slot.
	always_comb begin
		logic [7:0] step;
		logic [7:0] gap;
		step = fprs_step(rp.rate);
		gap = 8'h00;
		d = q;
		if (!rp.enable) begin
			d.duty = rp.target;
		end else if (rp.tick) begin
			if (q.duty < rp.target) begin
				gap = rp.target - q.duty;
				d.duty = (gap > step) ? q.duty + step : rp.target;
			end else begin
				gap = q.duty - rp.target;
				d.duty = (gap > step) ? q.duty - step : rp.target;
			end
		end
	end

	// State register.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rp.duty = q.duty;
endmodule // fprs_ramp
`default_nettype wire

// >>> core/fprs_axil.sv
/*
 AXI4-Lite slave for the ramp smoother registers.
 Assumes one write and one read at a time; lane 0 carries the data.
*/
`timescale 1ns/100ps
`default_nettype none
module fprs_axil
	import fprs_pkg::*;
(
	input wire logic ref_clk, // System clock.
	input wire logic reset, // Asynchronous reset, active high.
	input wire logic [3:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [3:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	fprs_reg_if.slave rg // Register file access.
);
	typedef struct packed {
		logic aw_h;
		logic [3:0] awaddr;
		logic w_h;
		logic [7:0] wdata;
		logic wstrb0;
		logic awrdy;
		logic wrdy;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fprs_axil_st_t;
	fprs_axil_st_t q, d;
	logic commit;

	// Address and data are held until both are in, then committed.
	assign commit = q.aw_h && q.w_h && !q.bvalid;

	// ------------------------------------------------------------
	// Channel handling
	// ------------------------------------------------------------
	// Readies are computed from the next state so they are flops.
	always_comb begin
		d = q;
		if (s_axi_awvalid && q.awrdy) begin
			d.aw_h = 1'b1;
			d.awaddr = {s_axi_awaddr[3:2], 2'h0};
		end
		if (s_axi_wvalid && q.wrdy) begin
			d.w_h = 1'b1;
			d.wdata = s_axi_wdata[7:0];
			d.wstrb0 = s_axi_wstrb[0];
		end
		if (s_axi_bready && q.bvalid) begin
			d.bvalid = 1'b0;
		end
		if (commit) begin
			d.aw_h = 1'b0;
			d.w_h = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = rg.wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		d.awrdy = !d.aw_h && !d.bvalid;
		d.wrdy = !d.w_h && !d.bvalid;
		if (s_axi_rready && q.rvalid) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arrdy) begin
			d.rvalid = 1'b1;
			d.rdata = rg.rd_ok ? rg.rd_data : 32'h00000000;
			d.rresp = rg.rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		d.arrdy = !d.rvalid;
	end

	// State register.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rg.wr_en = commit && q.wstrb0;
	assign rg.wr_addr = q.awaddr;
	assign rg.wr_data = q.wdata;
	assign rg.rd_addr = {s_axi_araddr[3:2], 2'h0};
	assign s_axi_awready = q.awrdy;
	assign s_axi_wready = q.wrdy;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arrdy;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
endmodule // fprs_axil
`default_nettype wire

// >>> core/fprs_top.sv
/*
 Fan drive ramp smoother: limits how fast the local and remote two
 fan drive outputs follow their computed duty targets.
 Assumes targets come from logic on ref_clk; registers over AXI4-Lite.
*/
// Decided for this implementation: the AXI4-Lite register port and the address map.
// What this block does
// - Local rate field sets local step size
// - Smoothing ramps gradually, never jumping to target
// - Fast base: codes give steps 1..48
// - Slow base gives longer time slot
// - Bit 3 enables local channel smoothing
// - Bits 6:4 set remote two step size
// - Bit 7 enables remote two smoothing
// - Lock bit makes control register read-only
`timescale 1ns/100ps
`default_nettype none
module fprs_top
	import fprs_pkg::*;
#(
	parameter int unsigned FAST_SLOT_CYCLES = 32'(FAST_SLOT_CYC),
	parameter int unsigned SLOW_SLOT_CYCLES = 32'(SLOW_SLOT_CYC)
)(
	input wire logic ref_clk, // System clock, 100 MHz.
	input wire logic reset, // Asynchronous reset, active high.
	input wire logic [3:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [3:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic [7:0] local_target_duty, // Computed local duty.
	input wire logic [7:0] remote_two_target_duty, // Computed duty.
	output logic [7:0] fan_drive_local, // Smoothed local duty.
	output logic [7:0] fan_drive_remote_two // Smoothed duty.
);
	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	if (FAST_SLOT_CYCLES < 2 || SLOW_SLOT_CYCLES < 2) begin : g_chk
		$error("fprs_top: slot lengths must be at least two cycles");
	end

	typedef struct packed {
		logic [7:0] ctrl;
		logic lock;
		logic slow;
		logic [31:0] cnt;
		logic tick;
	} fprs_top_st_t;
	fprs_top_st_t q, d;
	logic [31:0] lim;

	fprs_reg_if rg();
	fprs_ramp_if lif();
	fprs_ramp_if rif();

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	fprs_axil u_axil (
		.ref_clk(ref_clk),
		.reset(reset),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rg(rg.slave)
	);

	// ------------------------------------------------------------
	// Register file and time base
	// ------------------------------------------------------------
	// Slot length follows the selected time base.
	assign lim = q.slow ? SLOW_SLOT_CYCLES : FAST_SLOT_CYCLES;

	// Time slot counter, register writes and the lock.
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt >= lim - 32'h1) begin
			d.cnt = 32'h0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 32'h1;
		end
		if (rg.wr_en && rg.wr_addr == CTRL_OFS && !q.lock) begin
			d.ctrl = rg.wr_data;
		end
		if (rg.wr_en && rg.wr_addr == CFG_OFS) begin
			// The lock only clears by reset.
			d.lock = q.lock | rg.wr_data[CFG_LOCK_BIT];
			d.slow = rg.wr_data[CFG_SLOW_BIT];
		end
	end

	// Read data of each word; the status word holds both smoothed duties.
	always_comb begin
		rg.rd_data = 32'h00000000;
		rg.rd_ok = 1'b1;
		if (rg.rd_addr == CTRL_OFS) begin
			rg.rd_data[7:0] = q.ctrl;
		end else if (rg.rd_addr == CFG_OFS) begin
			rg.rd_data[CFG_LOCK_BIT] = q.lock;
			rg.rd_data[CFG_SLOW_BIT] = q.slow;
		end else if (rg.rd_addr == STAT_OFS) begin
			rg.rd_data[15:0] = {rif.duty, lif.duty};
		end else begin
			rg.rd_ok = 1'b0;
		end
	end

	// Writes to any mapped word answer OKAY; status is read-only.
	assign rg.wr_ok = (rg.wr_addr == CTRL_OFS) ||
		(rg.wr_addr == CFG_OFS) || (rg.wr_addr == STAT_OFS);

	// State register.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q <= '0;
			q.ctrl <= CTRL_RST;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Ramp channels
	// ------------------------------------------------------------
	// Local channel settings.
	assign lif.target = local_target_duty;
	assign lif.enable = q.ctrl[LOC_EN_BIT];
	assign lif.rate = q.ctrl[LOC_RATE_LSB +: 3];
	assign lif.tick = q.tick;
	// Remote two channel settings.
	assign rif.target = remote_two_target_duty;
	assign rif.enable = q.ctrl[R2_EN_BIT];
	assign rif.rate = q.ctrl[R2_RATE_LSB +: 3];
	assign rif.tick = q.tick;

	fprs_ramp u_ramp_local (
		.ref_clk(ref_clk),
		.reset(reset),
		.rp(lif.ramp)
	);

	fprs_ramp u_ramp_remote_two (
		.ref_clk(ref_clk),
		.reset(reset),
		.rp(rif.ramp)
	);

	assign fan_drive_local = lif.duty;
	assign fan_drive_remote_two = rif.duty;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// Local step up by the coded increment on a tick.
	property p_loc_up;
		logic [7:0] s;
		(q.tick && q.ctrl[LOC_EN_BIT] && lif.duty < lif.target &&
			lif.target - lif.duty > fprs_step(lif.rate),
			s = lif.duty + fprs_step(lif.rate))
		|=> fan_drive_local == s;
	endproperty
	a_loc_up: assert property (p_loc_up)
		else $error("local duty did not step by its rate");

	// No movement between ticks while smoothing.
	property p_hold;
		q.ctrl[LOC_EN_BIT] && !q.tick |=> $stable(fan_drive_local);
	endproperty
	a_hold: assert property (p_hold)
		else $error("local duty moved between time slots");

	// Fast base: tick follows the last count, then counting restarts.
	sequence s_fast_end;
		!q.slow && q.cnt == FAST_SLOT_CYCLES - 1;
	endsequence
	property p_fast;
		s_fast_end |=> q.tick ##1 !q.tick;
	endproperty
	a_fast: assert property (p_fast)
		else $error("fast time slot length wrong");

	// Slow base: no tick before the slow slot ends.
	property p_slow;
		q.slow && $past(q.slow) && q.tick |->
			$past(q.cnt) == SLOW_SLOT_CYCLES - 1;
	endproperty
	a_slow: assert property (p_slow)
		else $error("slow time slot length wrong");

	// A tick with a gap always moves the local duty.
	property p_loc_move;
		q.ctrl[LOC_EN_BIT] && q.tick && fan_drive_local != lif.target
		|=> fan_drive_local != $past(fan_drive_local);
	endproperty
	a_loc_move: assert property (p_loc_move)
		else $error("local smoothing did not move on a tick");

	// Remote two step down by its own coded increment.
	property p_r2_down;
		logic [7:0] s;
		(q.tick && q.ctrl[R2_EN_BIT] && rif.duty > rif.target &&
			rif.duty - rif.target > fprs_step(rif.rate),
			s = rif.duty - fprs_step(rif.rate))
		|=> fan_drive_remote_two == s;
	endproperty
	a_r2_down: assert property (p_r2_down)
		else $error("remote two duty did not step by its rate");

	// Remote two holds between ticks while smoothing.
	property p_r2_hold;
		q.ctrl[R2_EN_BIT] && !q.tick |=> $stable(fan_drive_remote_two);
	endproperty
	a_r2_hold: assert property (p_r2_hold)
		else $error("remote two duty moved between time slots");

	// Once locked the control word and the lock never change.
	property p_lock;
		q.lock |=> $stable(q.ctrl) && q.lock;
	endproperty
	a_lock: assert property (p_lock)
		else $error("control changed while locked");

	// Bypass follows the target one cycle later on both channels.
	property p_bypass;
		!q.ctrl[LOC_EN_BIT] && !q.ctrl[R2_EN_BIT] |=>
			fan_drive_local == $past(local_target_duty) &&
			fan_drive_remote_two == $past(remote_two_target_duty);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass output did not follow its target");

	// Local step down by the coded increment on a tick.
	property p_loc_down;
		logic [7:0] s;
		(q.tick && q.ctrl[LOC_EN_BIT] && lif.duty > lif.target &&
			lif.duty - lif.target > fprs_step(lif.rate),
			s = lif.duty - fprs_step(lif.rate))
		|=> fan_drive_local == s;
	endproperty
	a_loc_down: assert property (p_loc_down)
		else $error("local duty did not step down by its rate");

	// Remote two step up by its own coded increment.
	property p_r2_up;
		logic [7:0] s;
		(q.tick && q.ctrl[R2_EN_BIT] && rif.duty < rif.target &&
			rif.target - rif.duty > fprs_step(rif.rate),
			s = rif.duty + fprs_step(rif.rate))
		|=> fan_drive_remote_two == s;
	endproperty
	a_r2_up: assert property (p_r2_up)
		else $error("remote two duty did not step up by its rate");

	// The slot tick is a single-cycle pulse.
	property p_tick_pulse;
		q.tick |=> !q.tick;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse)
		else $error("slot tick lasted more than one cycle");

	// Slow base: the last slow count is followed by a tick.
	property p_slow_end;
		q.slow && q.cnt == SLOW_SLOT_CYCLES - 1 |=> q.tick;
	endproperty
	a_slow_end: assert property (p_slow_end)
		else $error("slow time slot did not end with a tick");

	// Local bypass on its own follows the target one cycle later.
	property p_loc_bypass;
		!q.ctrl[LOC_EN_BIT] |=>
			fan_drive_local == $past(local_target_duty);
	endproperty
	a_loc_bypass: assert property (p_loc_bypass)
		else $error("local bypass did not follow its target");

	// Remote two bypass on its own follows the target one cycle later.
	property p_r2_bypass;
		!q.ctrl[R2_EN_BIT] |=>
			fan_drive_remote_two == $past(remote_two_target_duty);
	endproperty
	a_r2_bypass: assert property (p_r2_bypass)
		else $error("remote two bypass did not follow its target");
endmodule // fprs_top
`default_nettype wire

// >>> tb/fprs_fan_model.sv
/*
 Model of the fan at the far side of one smoothed drive output.
 Assumes the drive changes on ref_clk; it records the largest one-cycle
 jump of the drive, which the fan would hear as a sudden speed change.
*/
`timescale 1ns/100ps
`default_nettype none
module fprs_fan_model (
	input wire logic ref_clk, // System clock.
	input wire logic reset, // Asynchronous reset, active high.
	input wire logic [7:0] duty, // Drive level seen by the fan.
	input wire logic clr, // Clears the jump record.
	output logic [7:0] jump_max // Largest jump seen since clear.
);
	logic [7:0] last_q;
	logic [7:0] diff;

	// Size of the change between this cycle and the last one.
	assign diff = (duty > last_q) ? duty - last_q : last_q - duty;

	// The motor follows the level; only the largest jump is kept.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			last_q <= 8'h00;
			jump_max <= 8'h00;
		end else begin
			last_q <= duty;
			if (clr)
				jump_max <= 8'h00;
			else if (diff > jump_max)
				jump_max <= diff;
		end
	end
endmodule // fprs_fan_model
`default_nettype wire

// >>> tb/tb_fprs_top.sv
/*
 Self-checking bench of the fan ramp smoother.
 Assumes short slot parameters so that each slot lasts a few cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_fprs_top;
	import fprs_pkg::*;
	// --------------------------------------------------------------
	// Signals
	// --------------------------------------------------------------
	localparam int FAST = 8;
	localparam int SLOW = 11;
	localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
		8'h08, 8'h0C, 8'h18, 8'h30};
	logic ref_clk, reset, fan_clr;
	logic [3:0] awaddr, araddr, wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] tgt_loc, tgt_r2, drv_loc, drv_r2, jmp_loc, jmp_r2;
	int error_cnt, n_compared;

	fprs_top #(.FAST_SLOT_CYCLES(FAST), .SLOW_SLOT_CYCLES(SLOW)) i_dut (
		.ref_clk(ref_clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.local_target_duty(tgt_loc), .remote_two_target_duty(tgt_r2),
		.fan_drive_local(drv_loc), .fan_drive_remote_two(drv_r2));
	fprs_fan_model i_fan_loc (.ref_clk(ref_clk), .reset(reset),
		.duty(drv_loc), .clr(fan_clr), .jump_max(jmp_loc));
	fprs_fan_model i_fan_r2 (.ref_clk(ref_clk), .reset(reset),
		.duty(drv_r2), .clr(fan_clr), .jump_max(jmp_r2));

	// Free-running 100 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("compared=%0d errors=%0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Next duty after one slot, clamped at the target.
	function automatic logic [7:0] nxt(input logic [7:0] v, t, s);
		if (v < t)
			return (t - v > s) ? v + s : t;
		return (v - t > s) ? v - s : t;
	endfunction

	// Write of one register word; each channel is held until taken.
	task automatic axi_wr(input logic [3:0] a, input logic [7:0] d,
		output logic [1:0] r);
		bit aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Only the watchdog ends a wait that never gets its answer.
		do begin
			@(posedge ref_clk);
			if (!aw_ok && awready) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end while (!(aw_ok && w_ok));
		do begin
			@(posedge ref_clk);
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	// Read of one register word; the address is held until taken.
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Ramps one channel and judges two slot steps and their spacing.
	task automatic ramp(input bit r2, input logic [2:0] code,
		input logic [7:0] from, to, input int slot);
		logic [7:0] s, e1, e2, v;
		logic [1:0] resp;
		int n;
		s = STEPS[code];
		e1 = nxt(from, to, s);
		e2 = nxt(e1, to, s);
		axi_wr(CTRL_OFS, 8'h00, resp);
		tgt_loc <= from;
		tgt_r2 <= from;
		repeat (3) @(posedge ref_clk);
		fan_clr <= 1'b1;
		@(posedge ref_clk);
		fan_clr <= 1'b0;
		axi_wr(CTRL_OFS, r2 ? {1'b1, code, 4'h0} : {4'h0, 1'b1, code}, resp);
		chk(resp, RESP_OKAY);
		if (r2)
			tgt_r2 <= to;
		else
			tgt_loc <= to;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
			v = r2 ? drv_r2 : drv_loc;
		end while (v === from && n < 3 * slot);
		chk(v, e1);
		repeat (slot - 1) @(posedge ref_clk);
		#1 chk(r2 ? drv_r2 : drv_loc, e1);
		@(posedge ref_clk);
		#1 chk(r2 ? drv_r2 : drv_loc, e2);
		chk(r2 ? jmp_r2 : jmp_loc, s);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(CTRL_OFS, d, r);
		chk(d, {24'h000000, CTRL_RST});
		axi_wr(CTRL_OFS, 8'hA5, r);
		axi_rd(CTRL_OFS, d, r);
		chk(d, 32'h000000A5);
		// A write with byte lane 0 off is answered but changes nothing.
		wstrb <= 4'h0;
		axi_wr(CTRL_OFS, 8'h5A, r);
		wstrb <= 4'hF;
		chk(r, RESP_OKAY);
		axi_rd(CTRL_OFS, d, r);
		chk(d, 32'h000000A5);
		// The status word is read-only: the write is answered OKAY.
		axi_wr(STAT_OFS, 8'h55, r);
		chk(r, RESP_OKAY);
		axi_rd(4'hC, d, r);
		chk(r, RESP_SLVERR);
		axi_wr(4'hC, 8'h11, r);
		chk(r, RESP_SLVERR);
	endtask

	// Smoothing off with both rate fields at their fastest code.
	task automatic t_direct();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(CTRL_OFS, 8'h77, r);
		tgt_loc <= 8'hFF;
		tgt_r2 <= 8'hFF;
		repeat (2) @(posedge ref_clk);
		#1 chk(drv_loc, 8'hFF);
		chk(drv_r2, 8'hFF);
		axi_rd(STAT_OFS, d, r);
		chk(d, 32'h0000FFFF);
	endtask

	task automatic t_rates();
		for (int c = 0; c < 8; c++)
			ramp(1'b0, 3'(c), 8'h0A, 8'hC8, FAST);
	endtask

	task automatic t_remote();
		ramp(1'b1, 3'h5, 8'hC8, 8'h14, FAST);
		ramp(1'b1, 3'h7, 8'h0A, 8'hC8, FAST);
	endtask

	task automatic t_slow();
		logic [1:0] r;
		axi_wr(CFG_OFS, 8'h02, r);
		ramp(1'b0, 3'h6, 8'hC8, 8'h0A, SLOW);
	endtask

	task automatic t_lock();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(CTRL_OFS, 8'h3C, r);
		axi_wr(CFG_OFS, 8'h01, r);
		axi_wr(CTRL_OFS, 8'hC3, r);
		chk(r, RESP_OKAY);
		axi_rd(CTRL_OFS, d, r);
		chk(d, 32'h0000003C);
	endtask

	// --------------------------------------------------------------
	// Main sequence and watchdog
	// --------------------------------------------------------------
	initial begin
		error_cnt = 0;
		n_compared = 0;
		reset = 1'b1;
		fan_clr = 1'b0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wstrb = 4'hF;
		wdata = 32'h00000000;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		tgt_loc = 8'h00;
		tgt_r2 = 8'h00;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_direct();
		t_rates();
		t_remote();
		t_slow();
		t_lock();
		finish_test();
	end

	// Cuts a hang short well beyond the few hundred cycles needed.
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		finish_test();
	end
endmodule // tb_fprs_top
`default_nettype wire
